// [inc/lbm_pkg.sv]
/*
 * Shared constants and types for the per-channel loopback and all-ones
 * selector of a three-channel line interface.
 * Assumes one control clock and one link clock per instance; the link
 * clock times the dual-rail bit stream, one bit per link edge.
 */
package lbm_pkg;

    localparam int          CH_NUM       = 3;
    localparam int          JA_DEPTH_DEF = 16;

    // Loop select code {remote, local}
    localparam logic [1:0]  SEL_NORMAL   = 2'h0;
    localparam logic [1:0]  SEL_ANALOG   = 2'h1;
    localparam logic [1:0]  SEL_REMOTE   = 2'h2;
    localparam logic [1:0]  SEL_DIGITAL  = 2'h3;

    // Attenuator path select values
    localparam logic        JA_IN_RX     = 1'h0;
    localparam logic        JA_IN_TX     = 1'h1;

    localparam logic [1:0]  RAIL_IDLE    = 2'h0;

    typedef enum logic [3:0] {
        LBM_NORMAL  = 4'h1,
        LBM_ANALOG  = 4'h2,
        LBM_REMOTE  = 4'h4,
        LBM_DIGITAL = 4'h8
    } lbm_mode_t;

    // One channel's settled selection
    typedef struct packed {
        lbm_mode_t mode;
        logic      aos;
        logic      ja_tx;
        logic      ja_en;
    } lbm_chctl_t;

    // Selection inputs, pin or host copy
    typedef struct packed {
        logic [CH_NUM-1:0] rlb;
        logic [CH_NUM-1:0] llb;
        logic [CH_NUM-1:0] aos;
        logic [CH_NUM-1:0] ja_tx;
        logic [CH_NUM-1:0] ja_en;
    } lbm_sel_t;

    // Control clock state
    typedef struct packed {
        lbm_sel_t                     pin_s1;
        lbm_sel_t                     pin_s2;
        logic                         hmode_s1;
        logic                         hmode_s2;
        lbm_chctl_t [CH_NUM-1:0]      word;
        logic                         req;
        logic                         ack_s1;
        logic                         ack_s2;
    } lbm_core_t;

    // Link clock state
    typedef struct packed {
        logic                         req_s1;
        logic                         req_s2;
        logic                         ack;
        lbm_chctl_t [CH_NUM-1:0]      ctl;
        logic [CH_NUM-1:0]            phase;
        logic [CH_NUM-1:0][1:0]       line_out;
        logic [CH_NUM-1:0][1:0]       rx_out;
        logic [CH_NUM-1:0]            rx_clk_tx;
        logic [CH_NUM-1:0]            tx_clk_rx;
    } lbm_link_t;

endpackage

// [rtl/lbm_top.sv]
/*
 * Loopback and all-ones path selector, three independent channels.
 * Selection pins are synchronised on core_clk, decoded, and the settled
 * per-channel selection crosses to link_clk by a toggle handshake.
 * The bit stream logic runs on link_clk: framer transmit rails and the
 * recovered line rails are assumed synchronous to link_clk. The jitter
 * attenuator is modelled as a fixed-depth delay line of rail pairs.
 */
`timescale 1ns/1ps

module lbm_top
    import lbm_pkg::*;
#(
    parameter int JA_DEPTH = JA_DEPTH_DEF
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     link_clk,
    input  wire logic                     host_mode,
    input  wire logic [CH_NUM-1:0]        remote_loop_select,
    input  wire logic [CH_NUM-1:0]        local_loop_select,
    input  wire logic [CH_NUM-1:0]        send_all_ones,
    input  wire logic [CH_NUM-1:0]        attenuator_path_select,
    input  wire logic [CH_NUM-1:0]        attenuator_enable,
    input  wire logic [CH_NUM-1:0]        host_remote_loop,
    input  wire logic [CH_NUM-1:0]        host_local_loop,
    input  wire logic [CH_NUM-1:0]        host_send_all_ones,
    input  wire logic [CH_NUM-1:0]        host_attenuator_path,
    input  wire logic [CH_NUM-1:0]        host_attenuator_enable,
    input  wire logic [CH_NUM-1:0]        tx_pos_data_in,
    input  wire logic [CH_NUM-1:0]        tx_neg_data_in,
    input  wire logic [CH_NUM-1:0]        line_rx_pos_in,
    input  wire logic [CH_NUM-1:0]        line_rx_neg_in,
    output logic      [CH_NUM-1:0]        line_tx_pos_out,
    output logic      [CH_NUM-1:0]        line_tx_neg_out,
    output logic      [CH_NUM-1:0]        rx_pos_rail_out,
    output logic      [CH_NUM-1:0]        rx_neg_rail_out,
    output logic      [CH_NUM-1:0]        rx_clk_from_tx,
    output logic      [CH_NUM-1:0]        tx_clk_from_rx,
    output lbm_chctl_t [CH_NUM-1:0]       sel_status
);

    function automatic lbm_mode_t decode_sel(input logic rlb,
                                             input logic llb);
        lbm_mode_t m;
        case ({rlb, llb})
            SEL_ANALOG:  m = LBM_ANALOG;
            SEL_REMOTE:  m = LBM_REMOTE;
            SEL_DIGITAL: m = LBM_DIGITAL;
            default:     m = LBM_NORMAL;
        endcase
        return m;
    endfunction

    // All-ones is suppressed in analog and remote loops
    function automatic logic aos_live(input lbm_chctl_t c);
        return c.aos && (c.mode != LBM_ANALOG) && (c.mode != LBM_REMOTE);
    endfunction

    lbm_core_t  c_r;
    lbm_core_t  c_nxt;
    lbm_link_t  l_r;
    lbm_link_t  l_nxt;
    logic       lrst_s1_n;
    logic       lrst_n;
    lbm_sel_t   pins_raw;
    lbm_sel_t   src;
    logic [1:0] ja_q [CH_NUM][JA_DEPTH];
    logic [CH_NUM-1:0][1:0] ja_in;
    logic [CH_NUM-1:0][1:0] ja_out;
    logic [CH_NUM-1:0][1:0] tx_pre;
    logic [CH_NUM-1:0][1:0] rx_in;
    logic [CH_NUM-1:0][1:0] rx_proc;

    assign pins_raw = '{rlb:   remote_loop_select,
                        llb:   local_loop_select,
                        aos:   send_all_ones,
                        ja_tx: attenuator_path_select,
                        ja_en: attenuator_enable};

    // Control clock: pin sync, selection and handshake source
    always_comb begin
        c_nxt          = c_r;
        c_nxt.pin_s1   = pins_raw;
        c_nxt.pin_s2   = c_r.pin_s1;
        c_nxt.hmode_s1 = host_mode;
        c_nxt.hmode_s2 = c_r.hmode_s1;
        c_nxt.ack_s1   = l_r.ack;
        c_nxt.ack_s2   = c_r.ack_s1;
        if (c_r.hmode_s2) begin
            src = '{rlb:   host_remote_loop,
                    llb:   host_local_loop,
                    aos:   host_send_all_ones,
                    ja_tx: host_attenuator_path,
                    ja_en: host_attenuator_enable};
        end else begin
            src = c_r.pin_s2;
        end
        // Word may change only while no transfer is in flight
        if (c_r.req == c_r.ack_s2) begin
            for (int i = 0; i < CH_NUM; i++) begin
                c_nxt.word[i].mode  = decode_sel(src.rlb[i],
                                                 src.llb[i]);
                c_nxt.word[i].aos   = src.aos[i];
                c_nxt.word[i].ja_tx = src.ja_tx[i];
                c_nxt.word[i].ja_en = src.ja_en[i];
            end
            if (c_nxt.word != c_r.word) begin
                c_nxt.req = ~c_r.req;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            c_r <= '0;
            for (int i = 0; i < CH_NUM; i++) begin
                c_r.word[i].mode <= LBM_NORMAL;
            end
        end else begin
            c_r <= c_nxt;
        end
    end

    // Link reset: asserted at once, released on link_clk
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_s1_n <= 1'h0;
            lrst_n    <= 1'h0;
        end else begin
            lrst_s1_n <= 1'h1;
            lrst_n    <= lrst_s1_n;
        end
    end

    // Link datapath, one independent lane per channel
    always_comb begin
        l_nxt        = l_r;
        l_nxt.req_s1 = c_r.req;
        l_nxt.req_s2 = l_r.req_s1;
        l_nxt.ack    = l_r.req_s2;
        if (l_r.req_s2 != l_r.ack) begin
            l_nxt.ctl = c_r.word;
        end
        for (int i = 0; i < CH_NUM; i++) begin
            // Analog loop takes the driven line pair, not the pins
            if (l_r.ctl[i].mode == LBM_ANALOG) begin
                rx_in[i] = l_r.line_out[i];
            end else begin
                rx_in[i] = {line_rx_pos_in[i], line_rx_neg_in[i]};
            end
            // Attenuator input follows its configured path
            if (l_r.ctl[i].ja_tx == JA_IN_TX) begin
                ja_in[i] = tx_pre_fn(i);
            end else begin
                ja_in[i] = rx_in[i];
            end
            ja_out[i] = l_r.ctl[i].ja_en ? ja_q[i][JA_DEPTH-1] : ja_in[i];
            rx_proc[i] = (l_r.ctl[i].ja_tx == JA_IN_TX) ? rx_in[i]
                                                        : ja_out[i];
            tx_pre[i] = tx_pre_fn(i);
            if (l_r.ctl[i].mode == LBM_REMOTE &&
                l_r.ctl[i].ja_tx == JA_IN_RX) begin
                tx_pre[i] = ja_out[i];
            end
            // Line output keeps running in every mode
            l_nxt.line_out[i] = (l_r.ctl[i].ja_tx == JA_IN_TX) ? ja_out[i]
                                                             : tx_pre[i];
            if (l_r.ctl[i].mode == LBM_DIGITAL) begin
                l_nxt.rx_out[i] = {tx_pos_data_in[i],
                                   tx_neg_data_in[i]};
            end else begin
                l_nxt.rx_out[i] = rx_proc[i];
            end
            // Mark phase advances on each link_clk edge while all-ones is live
            if (aos_live(l_r.ctl[i])) begin
                l_nxt.phase[i] = ~l_r.phase[i];
            end
            l_nxt.rx_clk_tx[i] = (l_r.ctl[i].mode == LBM_DIGITAL);
            l_nxt.tx_clk_rx[i] = (l_r.ctl[i].mode == LBM_REMOTE);
        end
    end

    // Transmit source before remote override; all-ones wins here
    function automatic logic [1:0] tx_pre_fn(input int i);
        logic [1:0] v;
        v = {tx_pos_data_in[i], tx_neg_data_in[i]};
        if (l_r.ctl[i].mode == LBM_REMOTE) begin
            v = rx_in[i];
        end else if (aos_live(l_r.ctl[i])) begin
            v = {l_r.phase[i], ~l_r.phase[i]};
        end
        return v;
    endfunction

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            l_r <= '0;
            for (int i = 0; i < CH_NUM; i++) begin
                l_r.ctl[i].mode <= LBM_NORMAL;
            end
        end else begin
            l_r <= l_nxt;
        end
    end

    // Attenuator delay line; depth trades latency for jitter margin
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            for (int i = 0; i < CH_NUM; i++) begin
                for (int k = 0; k < JA_DEPTH; k++) begin
                    ja_q[i][k] <= RAIL_IDLE;
                end
            end
        end else begin
            for (int i = 0; i < CH_NUM; i++) begin
                ja_q[i][0] <= ja_in[i];
                for (int k = 1; k < JA_DEPTH; k++) begin
                    ja_q[i][k] <= ja_q[i][k-1];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            line_tx_pos_out[i] = l_r.line_out[i][1];
            line_tx_neg_out[i] = l_r.line_out[i][0];
            rx_pos_rail_out[i] = l_r.rx_out[i][1];
            rx_neg_rail_out[i] = l_r.rx_out[i][0];
        end
        rx_clk_from_tx = l_r.rx_clk_tx;
        tx_clk_from_rx = l_r.tx_clk_rx;
        sel_status     = c_r.word;
    end

    sequence hs_start_s;
        $changed(c_r.req);
    endsequence

    sequence hs_done_s;
        ##[1:200] (c_r.req == c_r.ack_s2);
    endsequence

    mode_handshake_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        hs_start_s |-> hs_done_s)
        else $error("selection handshake did not complete");

    for (genvar g = 0; g < CH_NUM; g++) begin : g_chk
        mode_onehot_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            $onehot(l_r.ctl[g].mode))
            else $error("channel mode not one-hot");

        digital_rx_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (l_r.ctl[g].mode == LBM_DIGITAL) |=>
            (rx_pos_rail_out[g] == $past(tx_pos_data_in[g]) &&
             rx_neg_rail_out[g] == $past(tx_neg_data_in[g])))
            else $error("digital loop rails mismatch");

        analog_loop_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (l_r.ctl[g].mode == LBM_ANALOG && !l_r.ctl[g].ja_en) |=>
            (rx_pos_rail_out[g] == $past(line_tx_pos_out[g]) &&
             rx_neg_rail_out[g] == $past(line_tx_neg_out[g])))
            else $error("analog loop not fed from line output");

        analog_drive_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (l_r.ctl[g].mode == LBM_ANALOG && !l_r.ctl[g].ja_en) |=>
            (line_tx_pos_out[g] == $past(tx_pos_data_in[g])))
            else $error("analog loop stopped driving line");

        remote_tx_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (l_r.ctl[g].mode == LBM_REMOTE && !l_r.ctl[g].ja_en) |=>
            (line_tx_pos_out[g] == $past(line_rx_pos_in[g]) &&
             tx_clk_from_rx[g]))
            else $error("remote loop not returning line data");

        remote_rx_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (l_r.ctl[g].mode == LBM_REMOTE &&
             l_r.ctl[g].ja_tx == JA_IN_TX) |=>
            (rx_neg_rail_out[g] == $past(line_rx_neg_in[g])))
            else $error("remote loop lost receive rails");

        aos_pattern_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (aos_live(l_r.ctl[g]) && !l_r.ctl[g].ja_en)[*2] |=>
            (line_tx_pos_out[g] != line_tx_neg_out[g] &&
             line_tx_pos_out[g] != $past(line_tx_pos_out[g])))
            else $error("all-ones pattern not alternating");

        aos_void_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (l_r.ctl[g].aos && l_r.ctl[g].mode == LBM_REMOTE) |=>
            $stable(l_r.phase[g]))
            else $error("all-ones active in remote loop");

        digital_clk_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (l_r.ctl[g].mode == LBM_DIGITAL) |=> rx_clk_from_tx[g])
            else $error("digital loop not timed by transmit clock");

        remote_ignore_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (l_r.ctl[g].mode == LBM_REMOTE && !l_r.ctl[g].ja_en &&
             l_r.ctl[g].ja_tx == JA_IN_RX) |=>
            (line_tx_neg_out[g] == $past(line_rx_neg_in[g])))
            else $error("remote loop used framer rails");

        aos_digital_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (aos_live(l_r.ctl[g]) && !l_r.ctl[g].ja_en &&
             l_r.ctl[g].mode == LBM_DIGITAL) |=>
            (line_tx_pos_out[g] == $past(l_r.phase[g])))
            else $error("all-ones lost in digital loop");

        normal_rx_a: assert property (
            @(posedge link_clk) disable iff (!lrst_n)
            (l_r.ctl[g].mode == LBM_NORMAL && !l_r.ctl[g].ja_en &&
             l_r.ctl[g].ja_tx == JA_IN_RX) |=>
            (rx_pos_rail_out[g] == $past(line_rx_pos_in[g])))
            else $error("receive path not passing line rails");
    end

endmodule

// [tb/lbm_framer_model.sv]
/*
 * Behavioural framer facing the selector's system side.
 * Assumes the bench sets the wanted rails; they launch 1 ns after each
 * link_clk rising edge, one bit per edge.
 */
`timescale 1ns/1ps
module lbm_framer_model
    import lbm_pkg::*;
(
    input  wire logic              link_clk,
    input  wire logic [CH_NUM-1:0] tx_pos_want,
    input  wire logic [CH_NUM-1:0] tx_neg_want,
    output logic      [CH_NUM-1:0] tx_pos,
    output logic      [CH_NUM-1:0] tx_neg
);
    initial begin
        tx_pos = '0;
        tx_neg = '0;
    end
    // Clock and rails keep running during all-ones as well
    always @(posedge link_clk) begin
        #1;
        tx_pos = tx_pos_want;
        tx_neg = tx_neg_want;
    end
endmodule

// [tb/testbench.sv]
/*
 * Self-checking bench for the loopback and all-ones selector.
 * Assumes lbm_pkg, lbm_top and lbm_framer_model are compiled first.
 */
`timescale 1ns/1ps
module testbench;
    import lbm_pkg::*;
    localparam int JA_D = 4;
    logic                    core_clk = 1'b0;
    logic                    link_clk = 1'b0;
    logic                    rst_n    = 1'b0;
    logic                    hmode    = 1'b0;
    logic [CH_NUM-1:0]       rlb = '0, llb = '0, aos = '0, jap = '0, jae = '0;
    logic [CH_NUM-1:0]       hrlb = '0, hllb = '0, haos = '0;
    logic [CH_NUM-1:0]       hjap = '0, hjae = '0;
    logic [CH_NUM-1:0]       tpw = '0, tnw = '0, rpi = '0, rni = '0;
    logic [CH_NUM-1:0]       tp, tn, lp, ln, rp, rn, rck, tck, a;
    lbm_chctl_t [CH_NUM-1:0] sel;
    int                      fails   = 0;
    int                      n_tests = 0;

    always #4 core_clk = ~core_clk;
    // Link edges land on core falling edges, never on a sampling edge
    always #80 link_clk = ~link_clk;

    lbm_top #(.JA_DEPTH(JA_D)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
        .host_mode(hmode), .remote_loop_select(rlb),
        .local_loop_select(llb), .send_all_ones(aos),
        .attenuator_path_select(jap), .attenuator_enable(jae),
        .host_remote_loop(hrlb), .host_local_loop(hllb),
        .host_send_all_ones(haos), .host_attenuator_path(hjap),
        .host_attenuator_enable(hjae), .tx_pos_data_in(tp),
        .tx_neg_data_in(tn), .line_rx_pos_in(rpi), .line_rx_neg_in(rni),
        .line_tx_pos_out(lp), .line_tx_neg_out(ln), .rx_pos_rail_out(rp),
        .rx_neg_rail_out(rn), .rx_clk_from_tx(rck), .tx_clk_from_rx(tck),
        .sel_status(sel)
    );

    lbm_framer_model u_framer (
        .link_clk(link_clk), .tx_pos_want(tpw), .tx_neg_want(tnw),
        .tx_pos(tp), .tx_neg(tn)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic link_wait(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask

    // Bounded wait for the settled word, then time for the link side
    task automatic wait_sel(input lbm_chctl_t [CH_NUM-1:0] w);
        int i;
        for (i = 0; i < 100 && sel !== w; i++) begin
            @(posedge core_clk);
        end
        if (sel !== w) begin
            fails++;
            final_report();
        end
        link_wait(8 + JA_D);
        check(32'(sel), 32'(w));
    endtask

    task automatic drive_pins(input logic [2:0] r, l, s);
        @(posedge core_clk);
        #1;
        rlb = r;
        llb = l;
        aos = s;
    endtask

    // Toggling channels flip each edge with neg as inverse of pos
    task automatic toggles(input logic [2:0] exp);
        a = lp;
        link_wait(1);
        check(32'(lp ^ a), 32'(exp));
        check(32'((lp ^ ln) & exp), 32'(exp));
    endtask

    task automatic t_reset();
        // Twelve core cycles still span one link edge to clear link state
        repeat (12) @(posedge core_clk);
        check(32'(sel), 32'({3{LBM_NORMAL, 3'h0}}));
        check(32'({lp, ln, rp, rn}), 32'h000);
        #1;
        rst_n = 1'b1;
        link_wait(4);
        $display("test reset done");
    endtask

    task automatic t_normal();
        @(posedge link_clk);
        #1;
        tpw = 3'h7;
        rni = 3'h7;
        link_wait(6);
        check(32'({lp, ln}), 32'h38);
        check(32'({rp, rn}), 32'h07);
        $display("test normal done");
    endtask

    // Digital on 0, analog on 1, remote on 2, all at once
    task automatic t_mixed();
        lbm_chctl_t [CH_NUM-1:0] w;
        drive_pins(3'h5, 3'h3, 3'h0);
        w = {LBM_REMOTE, 3'h0, LBM_ANALOG, 3'h0, LBM_DIGITAL, 3'h0};
        wait_sel(w);
        check(32'({lp, ln}), 32'h1C);
        check(32'({rp, rn}), 32'h1C);
        check(32'({rck, tck}), 32'h0C);
        drive_pins(3'h5, 3'h3, 3'h7);
        w = {LBM_REMOTE, 3'h4, LBM_ANALOG, 3'h4, LBM_DIGITAL, 3'h4};
        wait_sel(w);
        toggles(3'h1);
        check(32'(lp & 3'h6), 32'h2);
        $display("test mixed done");
    endtask

    // Host bits override pins; attenuator on channel 0 only
    task automatic t_host();
        lbm_chctl_t [CH_NUM-1:0] w;
        @(posedge core_clk);
        #1;
        hmode = 1'b1;
        hrlb = 3'h1;
        haos = 3'h2;
        hjap = 3'h1;
        hjae = 3'h1;
        w = {LBM_NORMAL, 3'h0, LBM_NORMAL, 3'h4, LBM_REMOTE, 3'h3};
        wait_sel(w);
        check(32'({rp, rn}), 32'h07);
        check(32'(lp & 3'h5), 32'h4);
        check(32'({rck, tck}), 32'h01);
        toggles(3'h2);
        @(posedge link_clk);
        #1;
        rpi = 3'h1;
        rni = 3'h0;
        link_wait(3);
        check(32'(lp[0]), 32'h0);
        link_wait(5);
        check(32'({lp[0], rp[0]}), 32'h3);
        @(posedge core_clk);
        #1;
        hjap = 3'h0;
        w = {LBM_NORMAL, 3'h0, LBM_NORMAL, 3'h4, LBM_REMOTE, 3'h1};
        wait_sel(w);
        check(32'({rp, rn}), 32'h08);
        check(32'(lp & 3'h5), 32'h5);
        $display("test host done");
    endtask

    initial begin
        t_reset();
        t_normal();
        t_mixed();
        t_host();
        final_report();
    end
endmodule
